// [pas_regs.svh]
// constants for the phy address and status register bank
// assumes inclusion by the register bank, the master model and the bench
`ifndef PAS_REGS_SVH
`define PAS_REGS_SVH

// ----------------------------------------
// register location and field positions
// ----------------------------------------
`define PAS_REG_OFFSET 5'h19
`define PAS_BIT_JAB_DROP 11
`define PAS_BIT_NEG_EN 10
`define PAS_BIT_RSVD9 9
`define PAS_BIT_FAULT_EN 8
`define PAS_BIT_DUPLEX 7
`define PAS_BIT_SPEED10 6
`define PAS_BIT_CIM 5
`define PAS_ADDR_MSB 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define PAS_RST_ADDR 5'h00
`define PAS_RST_FAULT_EN 1'b0
`define PAS_RST_JAB_DROP 1'b0
`define PAS_RST_CIM 1'b0

// ----------------------------------------
// management frame timing in management clock bits, opcodes, and the strap wait in system clocks
// ----------------------------------------
`define PAS_PREAMBLE_BITS 6'h20
`define PAS_HDR_LAST 4'hc
`define PAS_DATA_BITS 5'h10
`define PAS_WDATA_LAST 5'h0f
`define PAS_OP_READ 2'h2
`define PAS_OP_WRITE 2'h1
`define PAS_STRAP_WAIT 2'h2

`endif

// [pas_pkg.sv]
// types for the phy address and status register bank
// assumes pas_regs.svh is on the include path
package pas_pkg;

	typedef enum logic [2:0] {
		PAS_PRE,
		PAS_HDR,
		PAS_TA,
		PAS_RDATA,
		PAS_WDATA
	} pas_frame_e;

	// level straps, sampled through synchronisers
	typedef struct packed {
		logic repeater;
		logic negotiation_strap_a;
		logic negotiation_strap_b;
		logic [4:0] station_address_bits;
	} pas_strap_s;

	// state from neighbouring logic on the system clock
	typedef struct packed {
		logic basic_control_neg_enable;
		logic basic_control_full_duplex;
		logic basic_control_speed_100;
		logic negotiated_full_duplex;
		logic negotiated_speed_10;
		logic basic_status_neg_complete;
		logic basic_status_link_up;
	} pas_mode_s;

endpackage

// [pas_phy_address_status.sv]
// phy address and status register with its serial management slave
// assumes mdc and mdio come from pins; mode, descrambler and monitor inputs are on clk_sys_in
//
// Function
// RQ1: bit 11 set: drop carrier sense after descrambler time-out.
// RQ2: bit 11 clear: hold carrier sense until descrambler resynchronizes.
// RQ3: bit 11 resets to inverse of the repeater strap.
// RQ4: bit 10 read-only shows negotiation enabled, from straps or basic control.
// RQ5: bit 8 read/write enables far-end fault indication; resets to zero.
// RQ6: bit 7 read-only reports full duplex as one, half as zero.
// RQ7: duplex and speed bits valid when negotiation off, complete, or link up.
// RQ8: bit 6 read-only reads one for 10 Mb/s, zero for 100 Mb/s.
// RQ9: bit 5 latched flag reports unstable link; resets to zero.
// RQ10: led select routes integrity monitor flag to first led output.
// RQ11: software writes reserved bits as zero and ignores their read value.
// RQ12: low five bits capture address straps; zero address sets isolate.
// RQ13: latched monitor flag holds until read, then follows current state.
`timescale 1ns/1ps
`include "pas_regs.svh"

module pas_phy_address_status
	import pas_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic mdc_in,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_out,
	input wire pas_strap_s strap_in,
	input wire pas_mode_s mode_in,
	input wire logic carrier_raw_in,
	input wire logic descrambler_timeout_in,
	input wire logic descrambler_locked_in,
	input wire logic monitor_unstable_in,
	input wire logic first_led_select_in,
	input wire logic led_normal_in,
	output logic carrier_sense_out,
	output logic first_led_output_out,
	output logic far_end_fault_enable_out,
	output logic isolate_out,
	output logic negotiation_enabled_out,
	output logic duplex_full_out,
	output logic speed_10_out,
	output logic status_valid_out
);

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [1:0] mdc_s_q;
	logic [1:0] mdio_s_q;
	pas_strap_s strap_s1_q;
	pas_strap_s strap_s2_q;
	logic mdc_last_q;
	logic mdc_rise;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mdc_s_q <= 2'h0;
			mdio_s_q <= 2'h3;
			strap_s1_q <= '0;
			strap_s2_q <= '0;
			mdc_last_q <= 1'b0;
		end else begin
			mdc_s_q <= {mdc_s_q[0], mdc_in};
			mdio_s_q <= {mdio_s_q[0], mdio_in};
			strap_s1_q <= strap_in;
			strap_s2_q <= strap_s1_q;
			mdc_last_q <= mdc_s_q[1];
		end
	end

	assign mdc_rise = mdc_s_q[1] & ~mdc_last_q;

	// ----------------------------------------
	// strap capture after reset release
	// ----------------------------------------
	// straps are levels, so they are taken once the synchroniser has filled
	logic [1:0] strap_wait_q;
	logic strap_take;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_wait_q <= 2'h0;
		end else if (strap_wait_q != `PAS_STRAP_WAIT + 2'h1) begin
			strap_wait_q <= strap_wait_q + 2'h1;
		end
	end

	assign strap_take = (strap_wait_q == `PAS_STRAP_WAIT);

	// ----------------------------------------
	// management frame engine
	// ----------------------------------------
	pas_frame_e state_q;
	logic [5:0] pre_cnt_q;
	logic [4:0] cnt_q;
	logic [12:0] hdr_q;
	logic [15:0] sh_q;
	logic is_read_q;
	logic hit_q;
	logic wr_q;
	logic rd_clr_q;
	logic [12:0] hdr_now;
	logic [15:0] rd_word;
	logic [4:0] addr_q;
	logic jab_drop_q;
	logic fault_en_q;
	logic cim_q;
	logic neg_en;
	logic duplex;
	logic speed10;

	assign hdr_now = {hdr_q[11:0], mdio_s_q[1]};

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= PAS_PRE;
			pre_cnt_q <= 6'h00;
			cnt_q <= 5'h00;
			hdr_q <= 13'h0000;
			sh_q <= 16'h0000;
			is_read_q <= 1'b0;
			hit_q <= 1'b0;
			wr_q <= 1'b0;
			rd_clr_q <= 1'b0;
			mdio_out <= 1'b1;
			mdio_oe_out <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			rd_clr_q <= 1'b0;
			if (mdc_rise) begin
				case (state_q)
					PAS_PRE: begin
						if (mdio_s_q[1]) begin
							if (pre_cnt_q != `PAS_PREAMBLE_BITS) begin
								pre_cnt_q <= pre_cnt_q + 6'h01;
							end
						end else begin
							// a zero after a full preamble is the first start bit
							if (pre_cnt_q == `PAS_PREAMBLE_BITS) begin
								state_q <= PAS_HDR;
								cnt_q <= 5'h00;
							end
							pre_cnt_q <= 6'h00;
						end
					end
					PAS_HDR: begin
						hdr_q <= hdr_now;
						cnt_q <= cnt_q + 5'h01;
						// thirteen header bits: start one, op, phy, reg
						if (cnt_q[3:0] == `PAS_HDR_LAST) begin
							cnt_q <= 5'h00;
							is_read_q <= (hdr_now[11:10] == `PAS_OP_READ);
							hit_q <= (hdr_now[9:5] == addr_q) && (hdr_now[4:0] == `PAS_REG_OFFSET);
							if (hdr_now[12] && ((hdr_now[11:10] == `PAS_OP_READ && hdr_now[9:5] == addr_q)
								|| hdr_now[11:10] == `PAS_OP_WRITE)) begin
								state_q <= PAS_TA;
							end else begin
								state_q <= PAS_PRE;
							end
						end
					end
					PAS_TA: begin
						cnt_q <= cnt_q + 5'h01;
						if (is_read_q) begin
							// the first turnaround bit is left to the wire; drive zero for the second
							mdio_out <= 1'b0;
							mdio_oe_out <= 1'b1;
							sh_q <= hit_q ? rd_word : 16'h0000;
							rd_clr_q <= hit_q;
							cnt_q <= 5'h00;
							state_q <= PAS_RDATA;
						end else if (cnt_q[0]) begin
							cnt_q <= 5'h00;
							state_q <= PAS_WDATA;
						end
					end
					PAS_RDATA: begin
						if (cnt_q == `PAS_DATA_BITS) begin
							mdio_oe_out <= 1'b0;
							mdio_out <= 1'b1;
							state_q <= PAS_PRE;
						end else begin
							mdio_out <= sh_q[15];
							sh_q <= {sh_q[14:0], 1'b0};
							cnt_q <= cnt_q + 5'h01;
						end
					end
					PAS_WDATA: begin
						sh_q <= {sh_q[14:0], mdio_s_q[1]};
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == `PAS_WDATA_LAST) begin
							wr_q <= hit_q;
							state_q <= PAS_PRE;
						end
					end
					default: begin
						state_q <= PAS_PRE;
						mdio_oe_out <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// register fields
	// ----------------------------------------
	// RQ11 reserved read zero
	always_comb begin
		rd_word = 16'h0000;
		rd_word[`PAS_BIT_JAB_DROP] = jab_drop_q;
		rd_word[`PAS_BIT_NEG_EN] = neg_en;
		rd_word[`PAS_BIT_FAULT_EN] = fault_en_q;
		rd_word[`PAS_BIT_DUPLEX] = duplex;
		rd_word[`PAS_BIT_SPEED10] = speed10;
		rd_word[`PAS_BIT_CIM] = cim_q;
		rd_word[`PAS_ADDR_MSB:0] = addr_q;
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			addr_q <= `PAS_RST_ADDR;
			jab_drop_q <= `PAS_RST_JAB_DROP;
			fault_en_q <= `PAS_RST_FAULT_EN;
			isolate_out <= 1'b0;
		end else if (strap_take) begin
			// RQ3 repeater strap default
			jab_drop_q <= ~strap_s2_q.repeater;
			// RQ12 address strap capture
			addr_q <= strap_s2_q.station_address_bits;
			isolate_out <= (strap_s2_q.station_address_bits == 5'h00);
		end else if (wr_q) begin
			jab_drop_q <= sh_q[`PAS_BIT_JAB_DROP];
			// RQ5 far-end fault enable
			fault_en_q <= sh_q[`PAS_BIT_FAULT_EN];
			addr_q <= sh_q[`PAS_ADDR_MSB:0];
		end
	end

	// RQ9 latched monitor flag
	// RQ13 set wins over read clear
	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cim_q <= `PAS_RST_CIM;
		end else begin
			cim_q <= monitor_unstable_in | (cim_q & ~rd_clr_q);
		end
	end

	// ----------------------------------------
	// mode status
	// ----------------------------------------
	// RQ4 negotiation enable source
	assign neg_en = mode_in.basic_control_neg_enable | (strap_s2_q.negotiation_strap_a & strap_s2_q.negotiation_strap_b);
	// RQ6 duplex selection
	assign duplex = neg_en ? mode_in.negotiated_full_duplex : mode_in.basic_control_full_duplex;
	// RQ8 speed selection
	assign speed10 = neg_en ? mode_in.negotiated_speed_10 : ~mode_in.basic_control_speed_100;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			negotiation_enabled_out <= 1'b0;
			duplex_full_out <= 1'b0;
			speed_10_out <= 1'b0;
			status_valid_out <= 1'b0;
			far_end_fault_enable_out <= 1'b0;
			first_led_output_out <= 1'b0;
		end else begin
			negotiation_enabled_out <= neg_en;
			duplex_full_out <= duplex;
			speed_10_out <= speed10;
			// RQ7 status validity
			status_valid_out <= ~neg_en | mode_in.basic_status_neg_complete | mode_in.basic_status_link_up;
			far_end_fault_enable_out <= fault_en_q;
			// RQ10 led routing
			first_led_output_out <= first_led_select_in ? cim_q : led_normal_in;
		end
	end

	// ----------------------------------------
	// carrier sense after descrambler time-out
	// ----------------------------------------
	logic timed_out_q;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			timed_out_q <= 1'b0;
			carrier_sense_out <= 1'b0;
		end else begin
			if (descrambler_timeout_in) begin
				timed_out_q <= 1'b1;
			end else if (descrambler_locked_in) begin
				timed_out_q <= 1'b0;
			end
			// RQ1 drop on time-out
			// RQ2 hold until resync
			carrier_sense_out <= timed_out_q ? ~jab_drop_q : carrier_raw_in;
		end
	end

endmodule

// [pas_checker_assertions.sv]
// assertions on the register bank ports
// assumes the bench link clock, mdc high for 13 system clocks
`timescale 1ns/1ps
module pas_checker
	import pas_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic mdc_in,
	input wire logic mdio_out,
	input wire logic mdio_oe_out,
	input wire pas_mode_s mode_in,
	input wire logic carrier_raw_in,
	input wire logic descrambler_timeout_in,
	input wire logic descrambler_locked_in,
	input wire logic monitor_unstable_in,
	input wire logic first_led_select_in,
	input wire logic led_normal_in,
	input wire logic carrier_sense_out,
	input wire logic first_led_output_out,
	input wire logic far_end_fault_enable_out,
	input wire logic negotiation_enabled_out,
	input wire logic duplex_full_out,
	input wire logic speed_10_out,
	input wire logic status_valid_out
);
	// ----
	// port relations
	// ----
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);
	chk_led_normal_path: assert property (
		!first_led_select_in |=> first_led_output_out == $past(led_normal_in)) else $error("led normal path");
	chk_led_flag_path: assert property (
		(first_led_select_in && monitor_unstable_in) ##1 first_led_select_in [*3] |-> first_led_output_out)
		else $error("led flag path");
	// three quiet cycles so either pipeline depth passes
	chk_carrier_follows_raw: assert property (
		(descrambler_locked_in && !descrambler_timeout_in && $stable(carrier_raw_in)) [*3]
		|=> carrier_sense_out == $past(carrier_raw_in)) else $error("carrier follow");
	chk_neg_enable_seen: assert property (
		(mode_in.basic_control_neg_enable && $stable(mode_in)) [*3] |-> negotiation_enabled_out)
		else $error("neg enable");
	chk_forced_mode: assert property (
		(!negotiation_enabled_out && $stable(mode_in)) [*3] |-> duplex_full_out == mode_in.basic_control_full_duplex
		&& speed_10_out == !mode_in.basic_control_speed_100) else $error("forced mode");
	chk_status_valid_rule: assert property (
		$stable(mode_in) [*3] |-> status_valid_out == (!negotiation_enabled_out
		|| mode_in.basic_status_neg_complete || mode_in.basic_status_link_up)) else $error("status valid");
	chk_fault_write_time: assert property (
		$changed(far_end_fault_enable_out) |-> mdc_in && $past(mdc_in, 2)) else $error("fault enable time");
	chk_turnaround_zero: assert property (
		$rose(mdio_oe_out) |-> !mdio_out) else $error("turnaround");
endmodule

bind pas_phy_address_status pas_checker chk (.*);

// [pas_mgmt_master.sv]
// management master model driving mdc and mdio frames
// assumes a pull-up on mdio, so a released line reads one
`timescale 1ns/1ps
`include "pas_regs.svh"
module pas_mgmt_master (
	input wire logic clk_sys_in,
	input wire logic mdio_in,
	output logic mdc_out = 1'b0,
	output logic mdio_out = 1'b1
);
	// ----
	// frame driver
	// ----
	// reserved bits go out as the bench gives them
	task automatic frame(logic [1:0] op, logic [4:0] phy, logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] sh;
		sh = {32'hffffffff, 2'b01, op, phy, `PAS_REG_OFFSET, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk_sys_in);
			mdc_out <= 1'b0;
			// let go of the line from the read turnaround on
			mdio_out <= (op == `PAS_OP_READ && i > 45) ? 1'b1 : sh[63 - i];
			repeat (12) @(posedge clk_sys_in);
			if (i > 47) begin
				rd[63 - i] = mdio_in;
			end
			mdc_out <= 1'b1;
			repeat (12) @(posedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		mdc_out <= 1'b0;
		mdio_out <= 1'b1;
	endtask
endmodule

// [tb_phy_address_status_register.sv]
// self-checking bench for the address and status register bank
// assumes the master model and the bound checker
`timescale 1ns/1ps
`include "pas_regs.svh"
module tb_phy_address_status_register
	import pas_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, raw = 1'b0, tmo = 1'b0, lock = 1'b1, mon = 1'b0, lsel = 1'b0, lnorm = 1'b0;
	logic mdc, mdio_m, dout, doe, cs, led, fault, iso, neg, dup, spd, sv, j, f, n;
	wire mdio_w = doe ? dout : mdio_m;
	pas_strap_s strap = 8'h00;
	pas_mode_s mode = 7'h00;
	logic [15:0] rd_word;
	logic [15:0] exp_q[$];
	logic [4:0] a;
	int errors = 0, total_checks = 0;
	event rd_ev;
	initial begin
		forever #2.5 clk = ~clk;
	end
	pas_phy_address_status dut (.clk_sys_in(clk), .arst_n_in(rst_n), .mdc_in(mdc), .mdio_in(mdio_w), .mdio_out(dout),
		.mdio_oe_out(doe), .strap_in(strap), .mode_in(mode), .carrier_raw_in(raw), .descrambler_timeout_in(tmo),
		.descrambler_locked_in(lock), .monitor_unstable_in(mon), .first_led_select_in(lsel), .led_normal_in(lnorm),
		.carrier_sense_out(cs), .first_led_output_out(led), .far_end_fault_enable_out(fault), .isolate_out(iso),
		.negotiation_enabled_out(neg), .duplex_full_out(dup), .speed_10_out(spd), .status_valid_out(sv));
	pas_mgmt_master m (.clk_sys_in(clk), .mdio_in(mdio_w), .mdc_out(mdc), .mdio_out(mdio_m));
	// ----
	// checks and bus tasks
	// ----
	task automatic ck_word(string s, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic ck_bit(string s, logic e, logic g);
		ck_word(s, {15'h0, e}, {15'h0, g});
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function automatic logic [15:0] ew(logic c);
		n = mode.basic_control_neg_enable | (strap.negotiation_strap_a & strap.negotiation_strap_b);
		return {4'h0, j, n, 1'b0, f, n ? mode.negotiated_full_duplex : mode.basic_control_full_duplex,
			n ? mode.negotiated_speed_10 : !mode.basic_control_speed_100, c, a};
	endfunction
	task automatic rd(logic [4:0] p, logic [15:0] e);
		exp_q.push_back(e);
		m.frame(`PAS_OP_READ, p, 16'h0000, rd_word);
		-> rd_ev;
	endtask
	task automatic wr(logic jj, logic ff);
		j = jj;
		f = ff;
		m.frame(`PAS_OP_WRITE, a, {4'h0, j, 2'h0, f, 3'h0, a}, rd_word);
	endtask
	task automatic reset(logic rep, logic [4:0] ad);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= {rep, 2'($urandom), ad};
		a = ad;
		j = !rep;
		f = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	always @(rd_ev) begin
		ck_word("read word", exp_q.pop_front(), rd_word);
	end
	initial begin
		void'($urandom(32'hd6fca02e));
		reset(1'b0, 5'($urandom_range(31, 1)));
		ck_bit("isolate", 1'b0, iso);
		rd(a, ew(1'b0));
		repeat (3) begin
			mode <= 7'($urandom);
			lnorm <= 1'($urandom);
			wr(1'($urandom), 1'($urandom));
			ck_bit("fault enable", f, fault);
			rd(a, ew(1'b0));
			ck_bit("valid", !n | mode.basic_status_neg_complete | mode.basic_status_link_up, sv);
			ck_bit("neg enabled", n, neg);
			ck_bit("duplex", n ? mode.negotiated_full_duplex : mode.basic_control_full_duplex, dup);
			ck_bit("speed", n ? mode.negotiated_speed_10 : !mode.basic_control_speed_100, spd);
		end
		for (int k = 0; k < 2; k++) begin
			wr(k[0], f);
			// raw carrier opposite to the expected held level, so a missed time-out shows
			raw <= j;
			lock <= 1'b0;
			tmo <= 1'b1;
			@(posedge clk);
			tmo <= 1'b0;
			repeat (4) @(posedge clk);
			ck_bit("carrier held", !j, cs);
			lock <= 1'b1;
			repeat (4) @(posedge clk);
			ck_bit("carrier resync", j, cs);
		end
		lsel <= 1'b1;
		lnorm <= 1'b0;
		mon <= 1'b1;
		@(posedge clk);
		mon <= 1'b0;
		repeat (4) @(posedge clk);
		ck_bit("led flag", 1'b1, led);
		rd(a, ew(1'b1));
		rd(a, ew(1'b0));
		ck_bit("led cleared", 1'b0, led);
		rd(a ^ 5'h10, 16'hffff);
		lsel <= 1'b0;
		reset(1'b1, 5'h00);
		ck_bit("isolate", 1'b1, iso);
		rd(5'h00, ew(1'b0));
		// let the compare process take the last read before the verdict
		@(posedge clk);
		summarize();
	end
endmodule
